/* File: src/psc_defines.vh */
// Purpose: Offsets, fields, codes and reset values of the port status block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave
`define PSC_OFS_STATUS      8'h00
`define PSC_OFS_BASE_LOW    8'h04
`define PSC_OFS_BASE_HIGH   8'h08
`define PSC_OFS_COMMAND     8'h0C
`define PSC_OFS_IRQ_STATUS  8'h10
`define PSC_OFS_IRQ_CLEAR   8'h14
`define PSC_OFS_IRQ_ENABLE  8'h18
`define PSC_OFS_UCODE_ADDR  8'h1C

// Status word fields
`define PSC_ST_FAULT_BIT    15
`define PSC_ST_CODE_HI      14
`define PSC_ST_CODE_LO      8
`define PSC_ST_TMO_BIT      7
`define PSC_ST_TYPE_HI      6
`define PSC_ST_TYPE_LO      4
`define PSC_ST_STATE_HI     3
`define PSC_ST_STATE_LO     0

// Command register bits
`define PSC_CMD_LOAD_PTR    0
`define PSC_CMD_ANCILLARY   1

// Interrupt status bits
`define PSC_IRQ_FAULT       0
`define PSC_IRQ_DONE        1
`define PSC_IRQ_CMD_ERR     14
`define PSC_IRQ_W           15

// Functional state codes
`define PSC_STATE_RESET     4'h0
`define PSC_STATE_PRIMARY   4'h1
`define PSC_STATE_READY     4'h2
`define PSC_STATE_RUNNING   4'h3
`define PSC_STATE_BUS_HALT  4'h5
`define PSC_STATE_NET_HALT  4'h6
`define PSC_STATE_BOTH_HALT 4'h7
`define PSC_STATE_PORT_HALT 4'h8

// Ancillary opcodes
`define PSC_OP_NOP          8'h00
`define PSC_OP_START_UCODE  8'h01

// Controller type code, value arbitrary
`define PSC_CTRL_TYPE       3'h6

// Reset values
`define PSC_RST_BASE        16'h0000
`define PSC_RST_IRQ         15'h0000

// AXI responses
`define PSC_RESP_OKAY       2'b00
`define PSC_RESP_SLVERR     2'b10

`endif

/* File: src/psc_fetch.v */
// Purpose: Bus-master read of the four control block words
// Assumes: Memory answers each request with one ack or err pulse
// Notes:   Words are kept in registers until the next fetch
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_fetch (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        start,
    input  wire [17:0] base,
    output reg         mem_req,
    output reg  [17:0] mem_addr,
    input  wire        mem_ack,
    input  wire        mem_err,
    input  wire [15:0] mem_rdata,
    output reg         done,
    output reg         fail,
    output reg  [15:0] word0,
    output reg  [15:0] word1,
    output reg  [15:0] word2,
    output reg  [15:0] word3
);
    reg [1:0] idx;      // Word being fetched
    reg       busy;     // Fetch in progress

    // Walk the four words, byte address advancing by two
    always @(posedge aclk) begin
        done <= 1'b0;
        fail <= 1'b0;
        if (!aresetn) begin
            busy     <= 1'b0;
            idx      <= 2'd0;
            mem_req  <= 1'b0;
            mem_addr <= 18'h0_0000;
            word0    <= 16'h0000;
            word1    <= 16'h0000;
            word2    <= 16'h0000;
            word3    <= 16'h0000;
        end else if (!busy) begin
            if (start) begin
                busy     <= 1'b1;
                idx      <= 2'd0;
                mem_req  <= 1'b1;
                mem_addr <= {base[17:1], 1'b0};
            end
        end else if (mem_err) begin
            // Bus timeout ends the fetch
            busy    <= 1'b0;
            mem_req <= 1'b0;
            fail    <= 1'b1;
        end else if (mem_ack) begin
            case (idx)
                2'd0: word0 <= mem_rdata;
                2'd1: word1 <= mem_rdata;
                2'd2: word2 <= mem_rdata;
                default: word3 <= mem_rdata;
            endcase
            if (idx == 2'd3) begin
                busy    <= 1'b0;
                mem_req <= 1'b0;
                done    <= 1'b1;
            end else begin
                idx      <= idx + 2'd1;
                mem_addr <= mem_addr + 18'h0_0002;
            end
        end
    end
endmodule

/* File: src/psc_top.v */
// Purpose: Port status register set and control block decoder, AXI4-Lite slave
// Assumes: One clock aclk at 20 MHz, synchronous active-low reset
// Notes:   Control block words fetched by psc_fetch on a 16-bit memory port
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "psc_defines.vh"

module psc_top (
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Fault report from self-test or microcode
    input  wire        fault_report,
    input  wire [6:0]  fault_code_in,
    // Halt conditions from the rest of the device
    input  wire        bus_halted,
    input  wire        net_halted,
    input  wire        port_halt,
    // Memory read port for the control block
    output wire        mem_req,
    output wire [17:0] mem_addr,
    input  wire        mem_ack,
    input  wire        mem_err,
    input  wire [15:0] mem_rdata,
    // Results
    output reg  [6:0]  fault_lamp,
    output reg         microcode_start,
    output reg  [23:0] microcode_start_addr,
    output wire        irq
);
    // State machine codes, one-hot
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_FETCH = 4'b0010;
    localparam [3:0] ST_EXEC  = 4'b0100;
    localparam [3:0] ST_DONE  = 4'b1000;

    reg  [3:0]  cmd_state;           // Ancillary command sequencer
    reg         fault_flag;          // Fault seen
    reg  [6:0]  fault_code;          // Last fault code
    reg         command_timeout_flag;// Bus timeout during command
    reg  [3:0]  func_state;          // Functional state field
    reg  [15:0] control_block_base_low;
    reg  [15:0] control_block_base_high;
    reg  [17:0] control_block_base;  // Active block pointer
    reg         ptr_valid;           // Pointer loaded since reset
    reg  [14:0] irq_status;          // Sticky events
    reg  [14:0] irq_enable;          // Event mask
    reg         fetch_start;         // Pulse to fetcher
    reg         ev_done;             // Command completed
    reg         ev_cmd_err;          // Command error
    // AXI write holding
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    wire        wr_fire;
    wire [15:0] port_status_word;
    wire        fetch_done;
    wire        fetch_fail;
    wire [15:0] blk0;
    wire [15:0] blk1;
    wire [15:0] blk2;
    reg  [31:0] rd_mux;              // Read data select
    reg         rd_ok;               // Read address mapped
    reg  [14:0] irq_clr;             // Clear pulses this cycle
    reg         cmd_load;            // Load pointer request
    reg         cmd_anc;             // Ancillary request

    // Channel readies: accept each half once, hold until response taken
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

    assign port_status_word = {fault_flag, fault_code, command_timeout_flag,
                               `PSC_CTRL_TYPE, func_state};

    // Level interrupt while any enabled event is pending
    assign irq = |(irq_status & irq_enable);

    // Capture write address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write decode pulses for clear and command registers
    always @* begin
        irq_clr  = 15'h0000;
        cmd_load = 1'b0;
        cmd_anc  = 1'b0;
        if (wr_fire && w_strb[0]) begin
            if (aw_addr == `PSC_OFS_IRQ_CLEAR) begin
                irq_clr[7:0] = w_data[7:0];
            end else if (aw_addr == `PSC_OFS_COMMAND) begin
                cmd_load = w_data[`PSC_CMD_LOAD_PTR];
                cmd_anc  = w_data[`PSC_CMD_ANCILLARY];
            end
        end
        if (wr_fire && w_strb[1] && aw_addr == `PSC_OFS_IRQ_CLEAR) begin
            irq_clr[14:8] = w_data[14:8];
        end
    end

    // Register writes and write response
    always @(posedge aclk) begin
        if (!aresetn) begin
            control_block_base_low  <= `PSC_RST_BASE;
            control_block_base_high <= `PSC_RST_BASE;
            irq_enable              <= `PSC_RST_IRQ;
            s_axi_bvalid            <= 1'b0;
            s_axi_bresp             <= `PSC_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `PSC_RESP_OKAY;
                if (aw_addr == `PSC_OFS_BASE_LOW) begin
                    if (w_strb[0]) begin
                        control_block_base_low[7:0] <= {w_data[7:1], 1'b0};
                    end
                    if (w_strb[1]) begin
                        control_block_base_low[15:8] <= w_data[15:8];
                    end
                end else if (aw_addr == `PSC_OFS_BASE_HIGH) begin
                    if (w_strb[0]) begin
                        control_block_base_high <= {14'h0000, w_data[1:0]};
                    end
                end else if (aw_addr == `PSC_OFS_IRQ_ENABLE) begin
                    if (w_strb[0]) begin
                        irq_enable[7:0] <= w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        irq_enable[14:8] <= w_data[14:8];
                    end
                end else if (aw_addr == `PSC_OFS_STATUS ||
                             aw_addr == `PSC_OFS_COMMAND ||
                             aw_addr == `PSC_OFS_IRQ_CLEAR) begin
                    s_axi_bresp <= `PSC_RESP_OKAY;
                end else begin
                    // Unmapped address, or read-only register other than status
                    s_axi_bresp <= `PSC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read data select
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (s_axi_araddr == `PSC_OFS_STATUS) begin
            rd_mux[15:0] = port_status_word;
        end else if (s_axi_araddr == `PSC_OFS_BASE_LOW) begin
            rd_mux[15:0] = control_block_base_low;
        end else if (s_axi_araddr == `PSC_OFS_BASE_HIGH) begin
            rd_mux[15:0] = control_block_base_high;
        end else if (s_axi_araddr == `PSC_OFS_COMMAND) begin
            rd_mux[0] = ptr_valid;
            rd_mux[1] = !cmd_state[0];
        end else if (s_axi_araddr == `PSC_OFS_IRQ_STATUS) begin
            rd_mux[14:0] = irq_status;
        end else if (s_axi_araddr == `PSC_OFS_IRQ_CLEAR) begin
            rd_mux = 32'h0000_0000;
        end else if (s_axi_araddr == `PSC_OFS_IRQ_ENABLE) begin
            rd_mux[14:0] = irq_enable;
        end else if (s_axi_araddr == `PSC_OFS_UCODE_ADDR) begin
            rd_mux[23:0] = microcode_start_addr;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read channel, one cycle answer
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Fault capture; only faults on fault_report reach this field
    always @(posedge aclk) begin
        if (!aresetn) begin
            fault_flag <= 1'b0;
            fault_code <= 7'h00;
        end else if (fault_report) begin
            fault_flag <= 1'b1;
            fault_code <= fault_code_in;
        end
    end

    // Lamp drive, one lamp per code bit, lowest first
    genvar li;
    generate
        for (li = 0; li < 7; li = li + 1) begin : g_lamp
            always @(posedge aclk) begin
                if (!aresetn) begin
                    fault_lamp[li] <= 1'b0;
                end else begin
                    fault_lamp[li] <= fault_code[li];
                end
            end
        end
    endgenerate

    // Control block fetcher
    // fetch four words
    psc_fetch u_fetch (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (fetch_start),
        .base      (control_block_base),
        .mem_req   (mem_req),
        .mem_addr  (mem_addr),
        .mem_ack   (mem_ack),
        .mem_err   (mem_err),
        .mem_rdata (mem_rdata),
        .done      (fetch_done),
        .fail      (fetch_fail),
        .word0     (blk0),
        .word1     (blk1),
        .word2     (blk2),
        .word3     ()
    );

    // Ancillary command sequencer
    always @(posedge aclk) begin
        fetch_start     <= 1'b0;
        ev_done         <= 1'b0;
        ev_cmd_err      <= 1'b0;
        microcode_start <= 1'b0;
        if (!aresetn) begin
            cmd_state            <= ST_IDLE;
            control_block_base   <= 18'h0_0000;
            ptr_valid            <= 1'b0;
            command_timeout_flag <= 1'b0;
            microcode_start_addr <= 24'h00_0000;
        end else begin
            case (cmd_state)
                ST_IDLE: begin
                    if (cmd_load) begin
                        control_block_base <= {control_block_base_high[1:0],
                                               control_block_base_low[15:1], 1'b0};
                        ptr_valid <= 1'b1;
                        ev_done   <= 1'b1;
                    end else if (cmd_anc) begin
                        if (ptr_valid) begin
                            fetch_start <= 1'b1;
                            cmd_state   <= ST_FETCH;
                        end else begin
                            command_timeout_flag <= 1'b0;
                            ev_cmd_err           <= 1'b1;
                        end
                    end
                end
                ST_FETCH: begin
                    if (fetch_fail) begin
                        command_timeout_flag <= 1'b1;
                        ev_cmd_err           <= 1'b1;
                        cmd_state            <= ST_IDLE;
                    end else if (fetch_done) begin
                        cmd_state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (blk0[7:0] == `PSC_OP_NOP) begin
                        ev_done <= 1'b1;
                    end else if (blk0[7:0] == `PSC_OP_START_UCODE) begin
                        microcode_start_addr <= {blk2[7:0], blk1[15:1], 1'b0};
                        microcode_start      <= 1'b1;
                        ev_done              <= 1'b1;
                    end else begin
                        command_timeout_flag <= 1'b0;
                        ev_cmd_err           <= 1'b1;
                    end
                    cmd_state <= ST_DONE;
                end
                ST_DONE: begin
                    cmd_state <= ST_IDLE;
                end
                default: begin
                    cmd_state <= ST_IDLE;
                end
            endcase
        end
    end

    // Functional state field
    always @(posedge aclk) begin
        if (!aresetn) begin
            func_state <= `PSC_STATE_RESET;
        end else if (port_halt) begin
            func_state <= `PSC_STATE_PORT_HALT;
        end else if (microcode_start) begin
            func_state <= `PSC_STATE_RUNNING;
        end else if (func_state == `PSC_STATE_RESET) begin
            func_state <= `PSC_STATE_READY;
        end else if (func_state == `PSC_STATE_RUNNING ||
                     func_state == `PSC_STATE_BUS_HALT ||
                     func_state == `PSC_STATE_NET_HALT ||
                     func_state == `PSC_STATE_BOTH_HALT) begin
            if (bus_halted && net_halted) begin
                func_state <= `PSC_STATE_BOTH_HALT;
            end else if (bus_halted) begin
                func_state <= `PSC_STATE_BUS_HALT;
            end else if (net_halted) begin
                func_state <= `PSC_STATE_NET_HALT;
            end else begin
                func_state <= `PSC_STATE_RUNNING;
            end
        end
    end

    // Sticky interrupt status, set wins over clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= `PSC_RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~irq_clr)
                        | ({14'h0000, fault_report} << `PSC_IRQ_FAULT)
                        | ({14'h0000, ev_done} << `PSC_IRQ_DONE)
                        | ({14'h0000, ev_cmd_err} << `PSC_IRQ_CMD_ERR);
        end
    end
endmodule

/* File: tb/psc_mem_model.sv */
// Purpose: Memory holding the control block, read by the block
// Assumes: One ack or err pulse answers each requested word
// Notes:   lat sets the wait; err_mode answers with a bus timeout
`timescale 1ns/1ps
module psc_mem_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        mem_req,
    input  wire logic [17:0] mem_addr,
    input  wire logic [3:0]  lat,
    input  wire logic        err_mode,
    output logic             mem_ack = 0,
    output logic             mem_err = 0,
    output logic [15:0]      mem_rdata = 0
);
    logic [15:0] m [int];  // Words by byte address
    logic [3:0]  cnt = 0;  // Wait counter
    // one 16-bit word per request, idle data toggles
    always @(posedge aclk) begin
        mem_ack   <= 0;
        mem_err   <= 0;
        mem_rdata <= ~mem_rdata;
        if (!aresetn || !mem_req || mem_ack || mem_err)
            cnt <= 0;
        else if (cnt < lat)
            cnt <= cnt + 1;
        else begin
            mem_ack   <= !err_mode;
            mem_err   <= err_mode;
            mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : 16'h0000;
        end
    end
endmodule

/* File: tb/psc_top_monitor.sv */
// Purpose: Port checker of the status block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every psc_top instance
`timescale 1ns/1ps
module psc_top_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        fault_report,
    input wire logic [6:0]  fault_code_in,
    input wire logic        mem_req,
    input wire logic [17:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        mem_err,
    input wire logic [6:0]  fault_lamp,
    input wire logic        microcode_start,
    input wire logic [23:0] microcode_start_addr
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_lamp_mirror: assert property (
        fault_report |=> ##1 fault_lamp == $past(fault_code_in, 2)) else $error("lamp");
    chk_fetch_step: assert property (
        mem_req && mem_ack |=> !mem_req || mem_addr == $past(mem_addr) + 18'd2)
        else $error("fetch step");
    chk_addr_hold: assert property (
        mem_req && !mem_ack && !mem_err |=> !mem_req || $stable(mem_addr)) else $error("addr");
    chk_start_cause: assert property (
        microcode_start |-> $past(mem_ack, 2) || $past(mem_ack, 3)) else $error("start");
    chk_start_even: assert property (
        microcode_start |-> !microcode_start_addr[0]) else $error("odd start");
    chk_start_pulse: assert property (
        microcode_start |=> !microcode_start) else $error("start width");
    chk_read_done: assert property (
        $fell(s_axi_rvalid) |-> $past(s_axi_rready)) else $error("rvalid");
    chk_write_done: assert property (
        $fell(s_axi_bvalid) |-> $past(s_axi_bready)) else $error("bvalid");
    cov_fault: cover property (fault_report);
    cov_start: cover property (microcode_start);
    cov_err: cover property (mem_err);
endmodule
bind psc_top psc_top_monitor i_mon (.*);

/* File: tb/psc_top_tb.sv */
// Purpose: Self-checking bench of the status block
// Assumes: AXI4-Lite master tasks, memory model on the fetch port
// Notes:   Expected values come from the bench model below
`timescale 1ns/1ps
`include "psc_defines.vh"
module psc_top_tb;
    logic aclk = 0, aresetn = 0, fault_report = 0, err_mode = 0;
    logic bus_halted = 0, net_halted = 0, port_halt = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, d;
    logic [3:0] s_axi_wstrb = 4'h3, lat = 0, state = 0;
    logic [6:0] fault_code_in = 0, code = 0;
    logic [15:0] w1, w2;
    logic [1:0] rs;
    logic fl = 0, tmo = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire mem_req, mem_ack, mem_err, microcode_start, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [17:0] mem_addr;
    wire [15:0] mem_rdata;
    wire [6:0] fault_lamp;
    wire [23:0] microcode_start_addr;
    int err_total = 0, compares = 0, seed = 94, n, starts = 0;
    psc_top i_dut (.*);
    psc_mem_model i_mem (.*);
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) if (microcode_start) starts <= starts + 1;
    function logic [31:0] stw();
        stw = {16'h0000, fl, code, tmo, `PSC_CTRL_TYPE, state};
    endfunction
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wrap_up;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task lim(input int k);
        if (k >= 60) begin
            err_total++;
            wrap_up();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        n = 0;
        tb = 0;
        while (!tb) begin
            @(negedge aclk);
            {ta, tw, tb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            n++;
            lim(n);
        end
        s_axi_bready <= 0;
        chk("bresp", rs, er);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        logic ta, tv;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        n = 0;
        tv = 0;
        while (!tv) begin
            @(negedge aclk);
            {ta, tv, v, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
            n++;
            lim(n);
        end
        s_axi_rready <= 0;
    endtask
    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a, d);
        chk(nm, d, e);
    endtask
    task cmd(input logic [31:0] c);
        wr(`PSC_OFS_COMMAND, c, `PSC_RESP_OKAY);
        d = 2;
        for (int k = 0; d[1]; k++) begin
            rd(`PSC_OFS_COMMAND, d);
            lim(k);
        end
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        state = `PSC_STATE_READY;
        rc("status", `PSC_OFS_STATUS, stw());
        wr(`PSC_OFS_STATUS, $random(seed), `PSC_RESP_OKAY);
        rc("status_ro", `PSC_OFS_STATUS, stw());
        $display("test status done");
        for (int k = 0; k < 4; k++) begin
            w1 = 16'($random(seed)) & 16'hFFFE;
            wr(`PSC_OFS_BASE_LOW, {16'h0000, w1}, `PSC_RESP_OKAY);
            rc("base_low", `PSC_OFS_BASE_LOW, {16'h0000, w1});
            wr(`PSC_OFS_BASE_HIGH, 32'(k), `PSC_RESP_OKAY);
            rc("base_high", `PSC_OFS_BASE_HIGH, 32'(k));
        end
        wr(8'h40, 0, `PSC_RESP_SLVERR);
        rd(8'h40, d);
        chk("rresp", rs, `PSC_RESP_SLVERR);
        $display("test base done");
        wr(`PSC_OFS_IRQ_ENABLE, 32'h0000_4003, `PSC_RESP_OKAY);
        code = 7'($random(seed));
        fault_code_in <= code;
        fault_report <= 1;
        @(posedge aclk);
        fault_report <= 0;
        fl = 1;
        repeat (2) @(negedge aclk);
        chk("lamp", fault_lamp, code);
        chk("irq", irq, 1);
        rc("fault", `PSC_OFS_STATUS, stw());
        wr(`PSC_OFS_IRQ_CLEAR, 32'h0000_4003, `PSC_RESP_OKAY);
        chk("irq_clr", irq, 0);
        $display("test fault done");
        cmd(2);
        rc("no_ptr", `PSC_OFS_IRQ_STATUS, 32'h0000_4000);
        rc("no_ptr_st", `PSC_OFS_STATUS, stw());
        chk("irq_err", irq, 1);
        wr(`PSC_OFS_IRQ_CLEAR, 32'h0000_4000, `PSC_RESP_OKAY);
        $display("test no pointer done");
        wr(`PSC_OFS_BASE_LOW, 32'h0000_0100, `PSC_RESP_OKAY);
        wr(`PSC_OFS_BASE_HIGH, 32'h0000_0001, `PSC_RESP_OKAY);
        cmd(1);
        for (int k = 0; k < 4; k++) begin
            lat <= 4'($random(seed)) & 4'h3;
            err_mode <= (k == 2);
            w1 = 16'($random(seed)) & 16'hFFFE;
            w2 = 16'($random(seed)) & 16'h00FF;
            i_mem.m[32'h0001_0100] = (k == 1) ? 16'h0005 : 16'(k == 3);
            i_mem.m[32'h0001_0102] = w1;
            i_mem.m[32'h0001_0104] = w2;
            cmd(2);
            if (k == 1) tmo = 0;
            if (k == 2) tmo = 1;
            if (k == 3) state = `PSC_STATE_RUNNING;
            rc("irq_st", `PSC_OFS_IRQ_STATUS, (k % 3) ? 32'h4000 : 32'h2);
            rc("cmd_st", `PSC_OFS_STATUS, stw());
            wr(`PSC_OFS_IRQ_CLEAR, 32'h0000_4003, `PSC_RESP_OKAY);
        end
        chk("starts", starts, 1);
        chk("uaddr", microcode_start_addr, {w2[7:0], w1});
        $display("test command done");
        for (int k = 1; k < 4; k++) begin
            bus_halted <= k[0];
            net_halted <= k[1];
            state = 4'(4 + k);
            rc("halt", `PSC_OFS_STATUS, stw());
        end
        port_halt <= 1;
        state = `PSC_STATE_PORT_HALT;
        rc("port_halt", `PSC_OFS_STATUS, stw());
        $display("test state done");
        wrap_up();
    end
endmodule
